// >>> src/hct_host_port.sv
`timescale 1ns/1ns
`default_nettype none

module hct_host_port
    import hct_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // host pins (synchronised inside)
    input wire logic i_cs1,
    input wire logic i_cs2,
    input wire logic [2:0] i_addr,
    input wire logic i_host_write_strobe,
    input wire logic i_host_read_strobe,
    input wire logic [15:0] i_host_data,
    input wire logic i_request_select_pin,
    // legacy configuration write, same-clock logic
    input wire logic i_cfg_we,
    input wire logic [7:0] i_cfg_wdata,
    input wire logic i_legacy_read_phase,
    // sub-CPU side
    input wire hct_pkg::hct_sub_req_t i_sub,
    input wire logic i_own_drive_identity_bit,
    input wire logic i_transfer_started,
    input wire logic i_host_int_request,
    input wire logic i_busy_clear,
    // host data bus
    output logic [15:0] o_host_data,
    output logic [15:0] o_host_data_oe,
    output logic o_host_int,
    output logic o_host_int_oe,
    // sub-CPU view
    output logic o_command_interrupt,
    output logic o_soft_reset_interrupt,
    output logic [7:0] o_command_reg,
    output logic [7:0] o_features_reg,
    output logic [15:0] o_host_data_word,
    output logic o_data_write_pulse,
    output logic o_dma_selected,
    output logic o_pseudo_wide_read,
    output logic o_high_byte_first,
    output logic o_legacy_data_path,
    output logic o_legacy_fifo_path
);

    // =====================================================================
    // pin synchronisation
    logic [23:0] pins_sync;
    hct_host_req_t req;
    logic rq_pin;

    hct_sync #(.WIDTH(24)) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async({i_cs1, i_cs2, i_addr, i_host_write_strobe, i_host_read_strobe, i_host_data, i_request_select_pin}),
        .o_sync(pins_sync)
    );

    assign req = pins_sync[23:1];
    assign rq_pin = pins_sync[0];

    // strobe edge detection on synchronised levels
    logic wr_d_reg;
    logic rd_d_reg;
    logic wr_pulse;
    logic rd_pulse;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_d_reg <= 1'b0;
            rd_d_reg <= 1'b0;
        end else if (i_ce) begin
            wr_d_reg <= req.wr;
            rd_d_reg <= req.rd;
        end
    end

    assign wr_pulse = req.wr && !wr_d_reg;
    assign rd_pulse = req.rd && !rd_d_reg;

    // =====================================================================
    // address decode
    function automatic logic hit(input logic cmd_blk, input logic [2:0] a, input hct_host_req_t r);
        if (cmd_blk) begin
            hit = r.cs2 && !r.cs1 && (r.addr == a);
        end else begin
            hit = !r.cs2 && r.cs1 && (r.addr == a);
        end
    endfunction

    // =====================================================================
    // legacy host configuration
    logic [7:0] cfg_reg;
    logic dma_sel;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_reg <= CFG_RESET;
        end else if (i_ce && i_cfg_we) begin
            cfg_reg <= {4'h0, i_cfg_wdata[3:0]}; // upper nibble is don't-care
        end
    end

    assign dma_sel = !cfg_reg[CFG_DMA_REQ_SEL_BIT] && !rq_pin;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dma_selected <= 1'b0;
            o_pseudo_wide_read <= 1'b0;
            o_high_byte_first <= 1'b0;
            o_legacy_data_path <= 1'b0;
            o_legacy_fifo_path <= 1'b1;
        end else if (i_ce) begin
            o_dma_selected <= dma_sel;
            // only reads are widened; writes stay byte wide
            o_pseudo_wide_read <= dma_sel && cfg_reg[CFG_PSEUDO_WIDE_BIT] && i_legacy_read_phase;
            // order bit only matters in pseudo wide mode
            o_high_byte_first <= dma_sel && cfg_reg[CFG_PSEUDO_WIDE_BIT]
                && !cfg_reg[CFG_BYTE_ORDER_BIT];
            // suspend has no say over DMA
            o_legacy_data_path <= !dma_sel && i_transfer_started && !cfg_reg[CFG_SUSPEND_BIT];
            o_legacy_fifo_path <= !dma_sel && !(i_transfer_started && !cfg_reg[CFG_SUSPEND_BIT]);
        end
    end

    // =====================================================================
    // task-file registers shared with sub-CPU
    logic [15:0] data_reg;
    logic [7:0] err_reg;
    logic [7:0] feat_reg;
    logic [7:0] reason_reg;
    logic [7:0] count_reg;
    logic [7:0] bcl_reg;
    logic [7:0] bch_reg;
    logic drive_bit_reg;
    logic [7:0] status_reg;
    logic [7:0] cmd_reg;
    logic [7:0] devctl_reg;
    logic selected;
    logic cmd_wr;
    logic srst_wr;

    assign selected = (drive_bit_reg == i_own_drive_identity_bit);
    assign cmd_wr = wr_pulse && hit(1'b1, TF_CMD_STATUS, req);
    assign srst_wr = wr_pulse && hit(1'b0, CTL_DEV_CONTROL, req) && req.wdata[DEVCTL_SOFT_RESET_BIT];

    // host writes, then sub-CPU writes; sub-CPU wins a same-cycle clash
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_reg <= DATA_RESET;
            err_reg <= REG8_RESET;
            feat_reg <= REG8_RESET;
            reason_reg <= REG8_RESET;
            count_reg <= REG8_RESET;
            bcl_reg <= REG8_RESET;
            bch_reg <= REG8_RESET;
            drive_bit_reg <= 1'b0;
            cmd_reg <= REG8_RESET;
            devctl_reg <= REG8_RESET;
        end else if (i_ce) begin
            if (wr_pulse && hit(1'b1, TF_DATA, req)) begin
                data_reg <= req.wdata;
            end else if (wr_pulse && hit(1'b1, TF_FEAT_ERR, req)) begin
                feat_reg <= req.wdata[7:0];
            end else if (wr_pulse && hit(1'b1, TF_INT_REASON, req)) begin
                reason_reg <= req.wdata[7:0];
            end else if (wr_pulse && hit(1'b1, TF_SECTOR_COUNT, req)) begin
                count_reg <= req.wdata[7:0];
            end else if (wr_pulse && hit(1'b1, TF_BYTE_CNT_LO, req)) begin
                bcl_reg <= req.wdata[7:0];
            end else if (wr_pulse && hit(1'b1, TF_BYTE_CNT_HI, req)) begin
                bch_reg <= req.wdata[7:0];
            end else if (wr_pulse && hit(1'b1, TF_DRIVE_SELECT, req)) begin
                drive_bit_reg <= req.wdata[DRIVE_BIT_POS];
            end else if (cmd_wr) begin
                cmd_reg <= req.wdata[7:0];
            end else if (wr_pulse && hit(1'b0, CTL_DEV_CONTROL, req)) begin
                devctl_reg <= req.wdata[7:0];
            end
            // sub-CPU keeps the same registers in step
            if (i_sub.we) begin
                if (i_sub.addr == TF_DATA) begin
                    data_reg <= i_sub.data_word;
                end else if (i_sub.addr == TF_FEAT_ERR) begin
                    err_reg <= i_sub.wdata;
                end else if (i_sub.addr == TF_INT_REASON) begin
                    reason_reg <= i_sub.wdata;
                end else if (i_sub.addr == TF_SECTOR_COUNT) begin
                    count_reg <= i_sub.wdata;
                end else if (i_sub.addr == TF_BYTE_CNT_LO) begin
                    bcl_reg <= i_sub.wdata;
                end else if (i_sub.addr == TF_BYTE_CNT_HI) begin
                    bch_reg <= i_sub.wdata;
                end else if (i_sub.addr == TF_DRIVE_SELECT) begin
                    drive_bit_reg <= i_sub.wdata[DRIVE_BIT_POS];
                end
            end
        end
    end

    // busy flag; a setting event beats the sub-CPU clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status_reg <= STATUS_RESET;
        end else if (i_ce) begin
            if ((cmd_wr && (selected || req.wdata[7:0] == DIAG_COMMAND)) || srst_wr) begin
                status_reg[STATUS_BUSY_BIT] <= 1'b1;
            end else if (i_busy_clear) begin
                status_reg[STATUS_BUSY_BIT] <= 1'b0;
            end
            if (i_sub.we && i_sub.addr == TF_CMD_STATUS) begin
                status_reg[6:0] <= i_sub.wdata[6:0];
            end
        end
    end

    // sub-CPU event pulses
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_command_interrupt <= 1'b0;
            o_soft_reset_interrupt <= 1'b0;
            o_data_write_pulse <= 1'b0;
        end else if (i_ce) begin
            o_command_interrupt <= cmd_wr && (selected || req.wdata[7:0] == DIAG_COMMAND);
            o_soft_reset_interrupt <= srst_wr;
            o_data_write_pulse <= wr_pulse && hit(1'b1, TF_DATA, req);
        end
    end

    // =====================================================================
    // host interrupt: request sets, command write or status read clears
    logic int_pend_reg;
    logic status_rd;

    assign status_rd = rd_pulse && hit(1'b1, TF_CMD_STATUS, req); // alt status not included

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_pend_reg <= 1'b0;
        end else if (i_ce) begin
            if (i_host_int_request) begin
                int_pend_reg <= 1'b1; // set wins over clear
            end else if (cmd_wr || status_rd) begin
                int_pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_int <= 1'b0;
            o_host_int_oe <= 1'b0;
        end else if (i_ce) begin
            o_host_int <= int_pend_reg;
            o_host_int_oe <= !devctl_reg[DEVCTL_INT_DISABLE_BIT] && selected;
        end
    end

    // =====================================================================
    // read mux, registered; bus driven while the read strobe is held
    logic [15:0] rd_data;
    logic [15:0] rd_oe;

    always_comb begin
        rd_data = 16'h0000;
        rd_oe = 16'h00FF;
        if (hit(1'b1, TF_DATA, req)) begin
            rd_data = data_reg;
            rd_oe = 16'hFFFF;
        end else if (hit(1'b1, TF_FEAT_ERR, req)) begin
            rd_data = {8'h00, err_reg};
        end else if (hit(1'b1, TF_INT_REASON, req)) begin
            rd_data = {8'h00, reason_reg};
        end else if (hit(1'b1, TF_SECTOR_COUNT, req)) begin
            rd_data = {8'h00, count_reg};
        end else if (hit(1'b1, TF_BYTE_CNT_LO, req)) begin
            rd_data = {8'h00, bcl_reg};
        end else if (hit(1'b1, TF_BYTE_CNT_HI, req)) begin
            rd_data = {8'h00, bch_reg};
        end else if (hit(1'b1, TF_DRIVE_SELECT, req)) begin
            rd_data = {8'h00, DRIVE_SELECT_ONES | {3'h0, drive_bit_reg, 4'h0}};
        end else if (hit(1'b1, TF_CMD_STATUS, req) || hit(1'b0, CTL_DEV_CONTROL, req)) begin
            rd_data = {8'h00, status_reg};
        end else if (hit(1'b0, CTL_DRIVE_ADDRESS, req)) begin
            // drive address: bit 7 floats, low bits show own drive
            rd_data = {8'h00, 1'b0, 5'h1F, i_own_drive_identity_bit, !i_own_drive_identity_bit};
            rd_oe = 16'h007F;
        end else begin
            rd_oe = 16'h0000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_host_data <= 16'h0000;
            o_host_data_oe <= 16'h0000;
        end else if (i_ce) begin
            o_host_data <= rd_data;
            o_host_data_oe <= req.rd ? rd_oe : 16'h0000;
        end
    end

    // sub-CPU view of host-written registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_command_reg <= REG8_RESET;
            o_features_reg <= REG8_RESET;
            o_host_data_word <= DATA_RESET;
        end else if (i_ce) begin
            o_command_reg <= cmd_reg;
            o_features_reg <= feat_reg;
            o_host_data_word <= data_reg;
        end
    end

endmodule // hct_host_port

`default_nettype wire

// >>> src/hct_pkg.sv
package hct_pkg;

    // =====================================================================
    // host configuration register fields
    localparam int CFG_PSEUDO_WIDE_BIT = 0;
    localparam int CFG_BYTE_ORDER_BIT = 1;
    localparam int CFG_DMA_REQ_SEL_BIT = 2;
    localparam int CFG_SUSPEND_BIT = 3;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // =====================================================================
    // task-file addresses (three address lines)
    localparam logic [2:0] TF_DATA = 3'h0;
    localparam logic [2:0] TF_FEAT_ERR = 3'h1;
    localparam logic [2:0] TF_INT_REASON = 3'h2;
    localparam logic [2:0] TF_SECTOR_COUNT = 3'h3;
    localparam logic [2:0] TF_BYTE_CNT_LO = 3'h4;
    localparam logic [2:0] TF_BYTE_CNT_HI = 3'h5;
    localparam logic [2:0] TF_DRIVE_SELECT = 3'h6;
    localparam logic [2:0] TF_CMD_STATUS = 3'h7;
    localparam logic [2:0] CTL_DEV_CONTROL = 3'h6;
    localparam logic [2:0] CTL_DRIVE_ADDRESS = 3'h7;

    // =====================================================================
    // field positions and fixed values
    localparam int DRIVE_BIT_POS = 4;
    localparam logic [7:0] DRIVE_SELECT_ONES = 8'hE0;
    localparam int STATUS_BUSY_BIT = 7;
    localparam int DEVCTL_SOFT_RESET_BIT = 2;
    localparam int DEVCTL_INT_DISABLE_BIT = 1;
    localparam logic [7:0] DIAG_COMMAND = 8'h90;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [7:0] STATUS_RESET = 8'h80;

    // =====================================================================
    // host bus request
    typedef struct packed {
        logic cs1;
        logic cs2;
        logic [2:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } hct_host_req_t;

    // sub-CPU side shared register update
    typedef struct packed {
        logic we;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic [15:0] data_word;
    } hct_sub_req_t;

endpackage

// >>> src/hct_sync.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// two-flop synchroniser for pin inputs
module hct_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_reg <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule // hct_sync

`default_nettype wire

// >>> dv/hct_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// host adapter model: one access at a time on the task-file pins
module hct_host_model (
    input wire logic i_clk,
    input wire logic [15:0] i_data,
    input wire logic [15:0] i_data_oe,
    output var hct_pkg::hct_host_req_t o_req
);
    import hct_pkg::*;
    int hold = 5; // strobe edges; a slow host stretches this
    logic [15:0] last = 16'h0000;

    initial o_req = '0;

    // strobe held for hold edges, then low for at least four edges
    // released or undriven bits read as the inverse of their last level
    task automatic acc(input logic w, input logic c1, input logic c2, input logic [2:0] a,
                       input logic [15:0] d, output logic [15:0] q, output logic [15:0] qe);
        @(posedge i_clk);
        o_req <= {c1, c2, a, w, !w, w ? d : ~last};
        repeat (hold) @(posedge i_clk);
        qe = i_data_oe;
        q = (i_data & qe) | (~last & ~qe);
        last = w ? d : q;
        o_req.wr <= 1'b0;
        o_req.rd <= 1'b0;
        o_req.wdata <= ~last;
        repeat (3) @(posedge i_clk);
    endtask
endmodule // hct_host_model

`default_nettype wire

// >>> dv/hct_checker.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// port checker for the host port
module hct_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cs1,
    input wire logic i_cs2,
    input wire logic [2:0] i_addr,
    input wire logic i_host_write_strobe,
    input wire logic [15:0] i_host_data,
    input wire logic i_request_select_pin,
    input wire logic i_host_int_request,
    input wire logic o_command_interrupt,
    input wire logic o_soft_reset_interrupt,
    input wire logic o_host_int,
    input wire logic o_dma_selected,
    input wire logic o_pseudo_wide_read,
    input wire logic o_legacy_data_path,
    input wire logic o_legacy_fifo_path
);
    import hct_pkg::*;
    logic cmd_wr;
    logic srst_wr;

    // pin-level decode; pulses follow three edges later (two sync flops, one output register)
    assign cmd_wr = i_host_write_strobe && i_cs2 && !i_cs1 && (i_addr == TF_CMD_STATUS);
    assign srst_wr = i_host_write_strobe && i_cs1 && !i_cs2 && (i_addr == CTL_DEV_CONTROL)
                     && i_host_data[DEVCTL_SOFT_RESET_BIT];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_pin_high;
        i_request_select_pin [*5];
    endsequence
    sequence s_int_seen;
        ##[1:2] o_host_int;
    endsequence

    property p_cmd_cause;
        o_command_interrupt |-> $past(cmd_wr, 2);
    endproperty
    property p_cmd_pulse;
        o_command_interrupt |=> !o_command_interrupt;
    endproperty
    property p_cmd_clear;
        o_command_interrupt && !i_host_int_request && !$past(i_host_int_request) |-> ##[0:1] !o_host_int;
    endproperty
    property p_srst_cause;
        o_soft_reset_interrupt |-> $past(srst_wr, 2);
    endproperty
    property p_int_set;
        i_host_int_request |-> s_int_seen;
    endproperty
    property p_pin_dma;
        s_pin_high |-> !o_dma_selected;
    endproperty
    property p_pseudo_dma;
        o_pseudo_wide_read |-> o_dma_selected;
    endproperty
    property p_paths;
        o_legacy_data_path |-> !o_legacy_fifo_path && !o_dma_selected;
    endproperty

    a_cmd_cause: assert property (p_cmd_cause) else $error("command interrupt without command write");
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command interrupt longer than one cycle");
    a_cmd_clear: assert property (p_cmd_clear) else $error("host interrupt kept after command write");
    a_srst_cause: assert property (p_srst_cause) else $error("soft reset interrupt without cause");
    a_int_set: assert property (p_int_set) else $error("host interrupt not raised on request");
    a_pin_dma: assert property (p_pin_dma) else $error("dma selected with select pin high");
    a_pseudo_dma: assert property (p_pseudo_dma) else $error("pseudo wide read without dma");
    a_paths: assert property (p_paths) else $error("data path and fifo path together");
endmodule // hct_checker

bind hct_host_port hct_checker u_chk (.i_clk, .i_rst_n, .i_cs1, .i_cs2, .i_addr, .i_host_write_strobe,
    .i_host_data, .i_request_select_pin, .i_host_int_request, .o_command_interrupt, .o_soft_reset_interrupt,
    .o_host_int, .o_dma_selected, .o_pseudo_wide_read, .o_legacy_data_path, .o_legacy_fifo_path);

`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ns
`default_nettype none

// =====================================================================
// bench: random and corner accesses on the host port
module tb;
    import hct_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic rsp = 1'b0, cfg_we = 1'b0, lrp = 1'b0, own_id = 1'b0, ts = 1'b0, int_req = 1'b0, bclr = 1'b0;
    logic [7:0] cfg_d = 8'h00;
    hct_sub_req_t sub = '0;
    hct_host_req_t req;
    logic [15:0] hd, hoe, dword, q, qe;
    logic hint, hint_oe, command_interrupt, soft_reset_interrupt, dwp, dma, pwr, hbf, ldp, lfp;
    logic [7:0] cmd_reg, feat_reg;
    logic [31:0] r;
    int errors = 0, tests_run = 0, seed = 27371, cmd_cnt = 0, srst_cnt = 0, dw_cnt = 0;

    hct_host_port dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cs1(req.cs1), .i_cs2(req.cs2), .i_addr(req.addr),
        .i_host_write_strobe(req.wr), .i_host_read_strobe(req.rd), .i_host_data(req.wdata),
        .i_request_select_pin(rsp), .i_cfg_we(cfg_we), .i_cfg_wdata(cfg_d), .i_legacy_read_phase(lrp),
        .i_sub(sub), .i_own_drive_identity_bit(own_id), .i_transfer_started(ts), .i_host_int_request(int_req),
        .i_busy_clear(bclr), .o_host_data(hd), .o_host_data_oe(hoe), .o_host_int(hint), .o_host_int_oe(hint_oe),
        .o_command_interrupt(command_interrupt), .o_soft_reset_interrupt(soft_reset_interrupt), .o_command_reg(cmd_reg),
        .o_features_reg(feat_reg), .o_host_data_word(dword), .o_data_write_pulse(dwp), .o_dma_selected(dma),
        .o_pseudo_wide_read(pwr), .o_high_byte_first(hbf), .o_legacy_data_path(ldp), .o_legacy_fifo_path(lfp)
    );
    hct_host_model host (.i_clk(i_clk), .i_data(hd), .i_data_oe(hoe), .o_req(req));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    // pulse counters, sampled with settled values
    always @(posedge i_clk) begin
        cmd_cnt += command_interrupt;
        srst_cnt += soft_reset_interrupt;
        dw_cnt += dwp;
    end

    // =====================================================================
    // helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", n, e, g);
            errors++;
        end
    endtask
    task automatic hw(input logic c1, input logic c2, input logic [2:0] a, input logic [15:0] d);
        host.hold = ($random(seed) & 3) + 5;
        host.acc(1'b1, c1, c2, a, d, q, qe);
    endtask
    task automatic hr(input logic c1, input logic c2, input logic [2:0] a);
        host.hold = ($random(seed) & 3) + 5;
        host.acc(1'b0, c1, c2, a, 16'h0000, q, qe);
    endtask
    task automatic sw(input logic [2:0] a, input logic [7:0] v, input logic [15:0] w);
        @(posedge i_clk);
        sub <= '{we: 1'b1, addr: a, wdata: v, data_word: w};
        @(posedge i_clk);
        sub <= '0;
    endtask
    // one-cycle sub-CPU pulse: 0 busy clear, 1 host interrupt request
    task automatic pulse(input bit k);
        @(posedge i_clk);
        if (k) int_req <= 1'b1; else bclr <= 1'b1;
        @(posedge i_clk);
        int_req <= 1'b0;
        bclr <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    // expected {dma, pseudo wide, data path, high byte first}
    // wide reads only widen the read phase; order matters only when wide
    function automatic logic [3:0] cfg_exp(input logic [3:0] c, input logic pin, input logic t, input logic rp);
        logic d;
        d = !c[CFG_DMA_REQ_SEL_BIT] && !pin;
        return {d, d && c[CFG_PSEUDO_WIDE_BIT] && rp, !d && t && !c[CFG_SUSPEND_BIT],
                d && c[CFG_PSEUDO_WIDE_BIT] && !c[CFG_BYTE_ORDER_BIT]};
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog far beyond the expected run of under a thousand cycles
    initial begin
        #400000;
        errors++;
        stop_test;
    end

    // =====================================================================
    // main sequence
    initial begin
        logic [3:0] e;
        logic x;
        logic [7:0] code;
        int n;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk("dma_after_reset", 16'h0001, {15'h0, dma});
        hr(1'b0, 1'b1, TF_CMD_STATUS);
        chk("status_reset", {8'h00, STATUS_RESET}, {8'h00, q[7:0]});
        chk("status_oe", 16'h00FF, qe);
        // registers written by the sub-CPU seen by the host
        for (int i = 1; i < 7; i++) begin
            r = $random(seed);
            sw(i[2:0], r[7:0], 16'h0000);
            hr(1'b0, 1'b1, i[2:0]);
            // drive select keeps only its drive bit under the fixed ones
            code = (i == 6) ? (DRIVE_SELECT_ONES | {3'h0, r[4], 4'h0}) : r[7:0];
            chk("shared", {8'h00, code}, {8'h00, q[7:0]});
        end
        for (int i = 0; i < 2; i++) begin
            own_id <= i[0];
            hr(1'b1, 1'b0, CTL_DRIVE_ADDRESS);
            chk("drive_address", {9'h000, 5'h1F, i[0], !i[0]}, {9'h000, q[6:0]});
            chk("drive_address_oe", 16'h007F, qe);
        end
        hr(1'b1, 1'b1, TF_DATA);
        chk("refused_oe", 16'h0000, qe);
        // data word both ways once a transfer runs
        ts <= 1'b1;
        r = $random(seed);
        sw(TF_DATA, 8'h00, r[15:0]);
        hr(1'b0, 1'b1, TF_DATA);
        chk("data_read", r[15:0], q);
        r = $random(seed);
        hw(1'b0, 1'b1, TF_DATA, r[15:0]);
        chk("data_write", r[15:0], dword);
        chk("data_pulse", 16'h0001, 16'(dw_cnt));
        hw(1'b0, 1'b1, TF_FEAT_ERR, {8'h00, r[23:16]});
        chk("features", {8'h00, r[23:16]}, {8'h00, feat_reg});
        // commands: selected or not, plain or diagnostic
        own_id <= 1'b0;
        hw(1'b1, 1'b0, CTL_DEV_CONTROL, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            hw(1'b0, 1'b1, TF_DRIVE_SELECT, {11'h000, i[0], 4'h0});
            pulse(1'b0);
            n = cmd_cnt;
            r = $random(seed);
            code = i[1] ? DIAG_COMMAND : {1'b0, r[6:0]};
            x = !i[0] || i[1];
            hw(1'b0, 1'b1, TF_CMD_STATUS, {8'h00, code});
            chk("command_irq", {15'h0, x}, 16'(cmd_cnt - n));
            hr(1'b0, 1'b1, TF_CMD_STATUS);
            chk("busy", {15'h0, x}, {15'h0, q[STATUS_BUSY_BIT]});
            if (x) chk("command_reg", {8'h00, code}, {8'h00, cmd_reg});
        end
        // host interrupt: raise, alternate read, status read, command clear
        hw(1'b0, 1'b1, TF_DRIVE_SELECT, 16'h0000);
        pulse(1'b1);
        chk("int_raised", 16'h0003, {14'h0, hint_oe, hint});
        hr(1'b1, 1'b0, CTL_DEV_CONTROL);
        chk("int_alt_read", 16'h0001, {15'h0, hint});
        chk("alt_status", 16'h0080, {8'h00, q[7:0]});
        hr(1'b0, 1'b1, TF_CMD_STATUS);
        chk("int_status_read", 16'h0000, {15'h0, hint});
        pulse(1'b1);
        hw(1'b0, 1'b1, TF_CMD_STATUS, 16'h0000);
        chk("int_command", 16'h0000, {15'h0, hint});
        pulse(1'b1);
        hw(1'b1, 1'b0, CTL_DEV_CONTROL, 16'h0002);
        chk("int_disabled", 16'h0001, {14'h0, hint_oe, hint});
        hw(1'b1, 1'b0, CTL_DEV_CONTROL, 16'h0000);
        hw(1'b0, 1'b1, TF_DRIVE_SELECT, 16'h0010);
        chk("int_unselected", 16'h0000, {15'h0, hint_oe});
        // soft reset bit
        pulse(1'b0);
        n = srst_cnt;
        hw(1'b1, 1'b0, CTL_DEV_CONTROL, 16'h0004);
        chk("soft_reset_irq", 16'h0001, 16'(srst_cnt - n));
        hr(1'b0, 1'b1, TF_CMD_STATUS);
        chk("soft_reset_busy", 16'h0001, {15'h0, q[STATUS_BUSY_BIT]});
        hw(1'b1, 1'b0, CTL_DEV_CONTROL, 16'h0000);
        // every low nibble of the configuration against both pin levels
        for (int i = 0; i < 32; i++) begin
            r = $random(seed);
            @(posedge i_clk);
            cfg_we <= 1'b1;
            cfg_d <= {r[7:4], i[3:0]};
            rsp <= i[4];
            ts <= r[8];
            lrp <= r[9];
            @(posedge i_clk);
            cfg_we <= 1'b0;
            repeat (5) @(posedge i_clk);
            e = cfg_exp(i[3:0], i[4], r[8], r[9]);
            chk("dma", {15'h0, e[3]}, {15'h0, dma});
            chk("pseudo_wide", {15'h0, e[2]}, {15'h0, pwr});
            chk("byte_order", {15'h0, e[0]}, {15'h0, hbf});
            chk("paths", {14'h0, e[1], !e[3] && !e[1]}, {14'h0, ldp, lfp});
        end
        // second reset in mid-run clears the configuration
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        rsp <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        chk("reset_config", 16'h0002, {14'h0, dma, pwr});
        stop_test;
    end
endmodule // tb

`default_nettype wire
